/* File: design/dwc_cfg.svh */
`ifndef DWC_CFG_SVH
`define DWC_CFG_SVH

// Register addresses on the internal register port
`define DWC_ADDR_GENCFG 8'hD1
`define DWC_ADDR_TRIG 8'hD3

// General configuration register reset and field positions
`define DWC_GENCFG_RST 16'h01F0
`define DWC_F_SHAPE_HI 15
`define DWC_F_SHAPE_LO 14
`define DWC_F_LOCK 13
`define DWC_F_PMBUS 12
`define DWC_F_STEP_HI 11
`define DWC_F_STEP_LO 9
`define DWC_F_SLEW_HI 8
`define DWC_F_SLEW_LO 5
`define DWC_F_PDN_HI 4
`define DWC_F_PDN_LO 3
`define DWC_F_REFEN 2
`define DWC_F_SPAN_HI 1
`define DWC_F_SPAN_LO 0

// Trigger register fields
`define DWC_F_KEY_HI 15
`define DWC_F_KEY_LO 12
`define DWC_F_RUN 8
`define DWC_UNLOCK_KEY 4'h5

// Step interval code that disables slewing
`define DWC_SLEW_NONE 4'hF

// Power-down field values
`define DWC_PDN_ON 2'h0
`define DWC_PDN_HIZ 2'h2

// Code step sizes in LSBs
`define DWC_STEP_0 6'h01
`define DWC_STEP_1 6'h02
`define DWC_STEP_2 6'h03
`define DWC_STEP_3 6'h04
`define DWC_STEP_4 6'h06
`define DWC_STEP_5 6'h08
`define DWC_STEP_6 6'h10
`define DWC_STEP_7 6'h20

// Clock rate and per-step dwell times in ns
`define DWC_CLK_MHZ 200
`define DWC_T0_NS 25600
`define DWC_T1_NS 32000
`define DWC_T2_NS 38400
`define DWC_T3_NS 44800
`define DWC_T4_NS 204800
`define DWC_T5_NS 256000
`define DWC_T6_NS 512000
`define DWC_T7_NS 819200
`define DWC_T8_NS 1638400
`define DWC_T9_NS 2457600
`define DWC_T10_NS 3276800
`define DWC_T11_NS 4915200
`define DWC_T12_NS 6553600
`define DWC_T13_NS 8000
`define DWC_T14_NS 12000
`define DWC_CYC(ns) (`DWC_TMR_W'((ns) * `DWC_CLK_MHZ / 1000))
`define DWC_TMR_W 21
`define DWC_NUM_SLEW 15

`endif

/* File: design/dwc_pkg.sv */
package dwc_pkg;

  typedef enum logic [1:0] {
    DWC_SHAPE_TRI = 2'b00,
    DWC_SHAPE_SAW_UP = 2'b01,
    DWC_SHAPE_SAW_DN = 2'b10,
    DWC_SHAPE_SQUARE = 2'b11
  } dwc_shape_type;

  typedef enum logic [2:0] {
    DWC_ST_IDLE = 3'b000,
    DWC_ST_RISE = 3'b001,
    DWC_ST_FALL = 3'b010,
    DWC_ST_HOLD_HI = 3'b011,
    DWC_ST_HOLD_LO = 3'b100
  } dwc_state_type;

endpackage

/* File: design/dwc_step_timer.sv */
`timescale 1ns/1ps
`include "dwc_cfg.svh"

module dwc_step_timer
  import dwc_pkg::*;
#(
  parameter logic [`DWC_TMR_W-1:0] STEP_CYC [`DWC_NUM_SLEW] = '{
    `DWC_CYC(`DWC_T0_NS), `DWC_CYC(`DWC_T1_NS), `DWC_CYC(`DWC_T2_NS),
    `DWC_CYC(`DWC_T3_NS), `DWC_CYC(`DWC_T4_NS), `DWC_CYC(`DWC_T5_NS),
    `DWC_CYC(`DWC_T6_NS), `DWC_CYC(`DWC_T7_NS), `DWC_CYC(`DWC_T8_NS),
    `DWC_CYC(`DWC_T9_NS), `DWC_CYC(`DWC_T10_NS), `DWC_CYC(`DWC_T11_NS),
    `DWC_CYC(`DWC_T12_NS), `DWC_CYC(`DWC_T13_NS), `DWC_CYC(`DWC_T14_NS)}
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic [3:0] slew_sel,
  output logic tick_r
);

  logic [`DWC_TMR_W-1:0] cnt_r;
  logic [`DWC_TMR_W-1:0] limit;
  logic no_slew;

  assign no_slew = (slew_sel == `DWC_SLEW_NONE);
  assign limit = no_slew ? '0 : STEP_CYC[slew_sel] - `DWC_TMR_W'(1);

  // ----------------------------------------
  // Dwell counter
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (restart)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (cnt_r >= limit)
    begin
      cnt_r <= '0;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + `DWC_TMR_W'(1);
      tick_r <= 1'b0;
    end
  end

endmodule // dwc_step_timer

/* File: design/dwc_waveform_config.sv */
`timescale 1ns/1ps
`include "dwc_cfg.svh"

module dwc_waveform_config
  import dwc_pkg::*;
#(
  parameter int CODE_W = 10,
  parameter logic [`DWC_TMR_W-1:0] STEP_CYC [`DWC_NUM_SLEW] = '{
    `DWC_CYC(`DWC_T0_NS), `DWC_CYC(`DWC_T1_NS), `DWC_CYC(`DWC_T2_NS),
    `DWC_CYC(`DWC_T3_NS), `DWC_CYC(`DWC_T4_NS), `DWC_CYC(`DWC_T5_NS),
    `DWC_CYC(`DWC_T6_NS), `DWC_CYC(`DWC_T7_NS), `DWC_CYC(`DWC_T8_NS),
    `DWC_CYC(`DWC_T9_NS), `DWC_CYC(`DWC_T10_NS), `DWC_CYC(`DWC_T11_NS),
    `DWC_CYC(`DWC_T12_NS), `DWC_CYC(`DWC_T13_NS), `DWC_CYC(`DWC_T14_NS)}
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  output logic [15:0] reg_rd_data,
  input wire logic [CODE_W-1:0] margin_high,
  input wire logic [CODE_W-1:0] margin_low,
  output logic [CODE_W-1:0] wave_code,
  output logic wave_active,
  output logic regs_locked,
  output logic pmbus_enable,
  output logic ref_enable,
  output logic [1:0] output_gain_select,
  output logic gain_active,
  output logic powered_up,
  output logic powerdown_hiz,
  output logic powerdown_pulldown
);

  localparam int SW = CODE_W + 1;

  logic [15:0] general_configuration_r;
  logic waveform_run_r;
  logic [15:0] rd_data_r;
  logic [CODE_W-1:0] code_r;
  dwc_state_type state_r;
  logic gain_active_r;
  logic powered_up_r;
  logic pd_hiz_r;
  logic pd_pull_r;
  logic tick;
  logic wr_gencfg;
  logic wr_trig;
  logic key_ok;
  logic locked;
  dwc_shape_type waveform_shape;
  logic [5:0] step_lsb;
  logic [SW-1:0] step_ext;
  logic [SW-1:0] up_sum;
  logic [SW-1:0] dn_diff;
  logic up_hit;
  logic dn_hit;
  logic restart;

  assign wr_gencfg = reg_wr_en && (reg_addr == `DWC_ADDR_GENCFG);
  assign wr_trig = reg_wr_en && (reg_addr == `DWC_ADDR_TRIG);
  assign key_ok = (reg_wr_data[`DWC_F_KEY_HI:`DWC_F_KEY_LO] == `DWC_UNLOCK_KEY);
  assign locked = general_configuration_r[`DWC_F_LOCK];
  assign waveform_shape =
    dwc_shape_type'(general_configuration_r[`DWC_F_SHAPE_HI:`DWC_F_SHAPE_LO]);

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      general_configuration_r <= `DWC_GENCFG_RST;
    else if (wr_gencfg && !locked)
      general_configuration_r <= reg_wr_data;
    // unlock key clears the lock bit
    else if (wr_trig && key_ok)
      general_configuration_r[`DWC_F_LOCK] <= 1'b0;
  end

  // ----------------------------------------
  // Trigger run bit
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      waveform_run_r <= 1'b0;
    else if (wr_trig && (!locked || key_ok))
      waveform_run_r <= reg_wr_data[`DWC_F_RUN];
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rd_data_r <= 16'h0000;
    else if (reg_addr == `DWC_ADDR_GENCFG)
      rd_data_r <= general_configuration_r;
    else if (reg_addr == `DWC_ADDR_TRIG)
      rd_data_r <= 16'(waveform_run_r) << `DWC_F_RUN;
    else
      rd_data_r <= 16'h0000;
  end

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      gain_active_r <= 1'b0;
      powered_up_r <= 1'b0;
      pd_hiz_r <= 1'b1;
      pd_pull_r <= 1'b0;
    end
    else
    begin
      // gain applies only with internal reference
      gain_active_r <= general_configuration_r[`DWC_F_REFEN];
      powered_up_r <=
        general_configuration_r[`DWC_F_PDN_HI:`DWC_F_PDN_LO] == `DWC_PDN_ON;
      pd_hiz_r <=
        general_configuration_r[`DWC_F_PDN_HI:`DWC_F_PDN_LO] == `DWC_PDN_HIZ;
      pd_pull_r <= general_configuration_r[`DWC_F_PDN_LO];
    end
  end

  // ----------------------------------------
  // Step size
  // ----------------------------------------
  // step size decode
  always_comb
  begin
    unique case (general_configuration_r[`DWC_F_STEP_HI:`DWC_F_STEP_LO])
      3'h0: step_lsb = `DWC_STEP_0;
      3'h1: step_lsb = `DWC_STEP_1;
      3'h2: step_lsb = `DWC_STEP_2;
      3'h3: step_lsb = `DWC_STEP_3;
      3'h4: step_lsb = `DWC_STEP_4;
      3'h5: step_lsb = `DWC_STEP_5;
      3'h6: step_lsb = `DWC_STEP_6;
      3'h7: step_lsb = `DWC_STEP_7;
    endcase
  end

  assign step_ext = SW'(step_lsb);
  assign up_sum = SW'(code_r) + step_ext;
  assign dn_diff = SW'(code_r) - step_ext;
  assign up_hit = up_sum >= SW'(margin_high);
  assign dn_hit = SW'(code_r) < (SW'(margin_low) + step_ext);
  assign restart = (state_r == DWC_ST_IDLE);

  // dwell per step, 1111 ticks every cycle
  dwc_step_timer #(
    .STEP_CYC(STEP_CYC)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .restart(restart),
    .slew_sel(general_configuration_r[`DWC_F_SLEW_HI:`DWC_F_SLEW_LO]),
    .tick_r(tick)
  );

  // ----------------------------------------
  // Waveform generator
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state_r <= DWC_ST_IDLE;
      code_r <= '0;
    end
    // stop when run clears; restart on any unlocked config write
    else if (!waveform_run_r || (wr_gencfg && !locked))
      state_r <= DWC_ST_IDLE;
    else
    begin
      unique case (state_r)
        DWC_ST_IDLE:
        begin
          unique case (waveform_shape)
            DWC_SHAPE_TRI, DWC_SHAPE_SAW_UP:
            begin
              code_r <= margin_low;
              state_r <= DWC_ST_RISE;
            end
            DWC_SHAPE_SAW_DN:
            begin
              code_r <= margin_high;
              state_r <= DWC_ST_FALL;
            end
            DWC_SHAPE_SQUARE:
            begin
              code_r <= margin_high;
              state_r <= DWC_ST_HOLD_HI;
            end
          endcase
        end
        DWC_ST_RISE:
        begin
          if (tick)
          begin
            if (code_r >= margin_high)
            begin
              // triangle turns down at the top
              if (waveform_shape == DWC_SHAPE_TRI)
                state_r <= DWC_ST_FALL;
              else
                code_r <= margin_low;
            end
            else
              code_r <= up_hit ? margin_high : up_sum[CODE_W-1:0];
          end
        end
        DWC_ST_FALL:
        begin
          if (tick)
          begin
            if (code_r <= margin_low)
            begin
              // triangle turns up at the bottom
              if (waveform_shape == DWC_SHAPE_TRI)
                state_r <= DWC_ST_RISE;
              else
                code_r <= margin_high;
            end
            else
              code_r <= dn_hit ? margin_low : dn_diff[CODE_W-1:0];
          end
        end
        DWC_ST_HOLD_HI:
        begin
          if (tick)
          begin
            code_r <= margin_low;
            state_r <= DWC_ST_HOLD_LO;
          end
        end
        DWC_ST_HOLD_LO:
        begin
          if (tick)
          begin
            code_r <= margin_high;
            state_r <= DWC_ST_HOLD_HI;
          end
        end
        default:
          state_r <= DWC_ST_IDLE;
      endcase
    end
  end

  assign reg_rd_data = rd_data_r;
  assign wave_code = code_r;
  assign wave_active = waveform_run_r;
  // lock state for the rest of the register map
  assign regs_locked = general_configuration_r[`DWC_F_LOCK];
  assign pmbus_enable = general_configuration_r[`DWC_F_PMBUS];
  assign ref_enable = general_configuration_r[`DWC_F_REFEN];
  assign output_gain_select = general_configuration_r[`DWC_F_SPAN_HI:`DWC_F_SPAN_LO];
  assign gain_active = gain_active_r;
  assign powered_up = powered_up_r;
  assign powerdown_hiz = pd_hiz_r;
  assign powerdown_pulldown = pd_pull_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_reset_value: assert property (@(posedge ref_clk)
    $fell(reset) |-> general_configuration_r == `DWC_GENCFG_RST && !waveform_run_r)
    else $error("config register not at reset value");

  chk_lock_blocks: assert property (@(posedge ref_clk) disable iff (reset)
    wr_gencfg && locked |=> $stable(general_configuration_r))
    else $error("locked config register was written");

  chk_unlock_key: assert property (@(posedge ref_clk) disable iff (reset)
    wr_trig && key_ok |=> !regs_locked)
    else $error("unlock key did not clear lock");

  chk_key_run: assert property (@(posedge ref_clk) disable iff (reset)
    wr_trig && key_ok |=> waveform_run_r == $past(reg_wr_data[`DWC_F_RUN]))
    else $error("key write refused while locked");

  chk_pmbus_write: assert property (@(posedge ref_clk) disable iff (reset)
    wr_gencfg && !locked |=> pmbus_enable == $past(reg_wr_data[`DWC_F_PMBUS]))
    else $error("PMBus enable did not follow write");

  chk_pdn_hiz: assert property (@(posedge ref_clk) disable iff (reset)
    wr_gencfg && !locked ##1 !wr_gencfg |=>
      powerdown_hiz == ($past(reg_wr_data[`DWC_F_PDN_HI:`DWC_F_PDN_LO], 2) == `DWC_PDN_HIZ))
    else $error("high impedance decode wrong");

  chk_gain_gate: assert property (@(posedge ref_clk) disable iff (reset)
    !ref_enable ##1 !ref_enable |-> !gain_active)
    else $error("gain active without internal reference");

  chk_step_bound: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == DWC_ST_RISE && tick && !wr_gencfg && waveform_run_r &&
      code_r < margin_high |=> SW'(code_r) <= SW'($past(code_r)) + $past(step_ext))
    else $error("rising step larger than step size");

  chk_no_slew: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == DWC_ST_HOLD_HI && waveform_run_r && !reg_wr_en &&
      general_configuration_r[`DWC_F_SLEW_HI:`DWC_F_SLEW_LO] == `DWC_SLEW_NONE
      |-> ##[1:2] state_r == DWC_ST_HOLD_LO)
    else $error("no-slew square did not toggle");

  chk_saw_drop: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == DWC_ST_RISE && waveform_shape == DWC_SHAPE_SAW_UP && tick &&
      code_r >= margin_high && waveform_run_r && !wr_gencfg
      |=> code_r == $past(margin_low))
    else $error("sawtooth did not drop to lower code");

  chk_saw_jump: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == DWC_ST_FALL && waveform_shape == DWC_SHAPE_SAW_DN && tick &&
      code_r <= margin_low && waveform_run_r && !wr_gencfg
      |=> code_r == $past(margin_high))
    else $error("sawtooth did not jump to upper code");

  chk_tri_turn: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == DWC_ST_RISE && waveform_shape == DWC_SHAPE_TRI && tick &&
      code_r >= margin_high && waveform_run_r && !wr_gencfg
      |=> state_r == DWC_ST_FALL)
    else $error("triangle did not turn at top");

  chk_square_lvl: assert property (@(posedge ref_clk) disable iff (reset)
    state_r == DWC_ST_HOLD_LO && tick && waveform_run_r && !wr_gencfg
      |=> state_r == DWC_ST_HOLD_HI && code_r == $past(margin_high))
    else $error("square did not return high");

  chk_run_stop: assert property (@(posedge ref_clk) disable iff (reset)
    !waveform_run_r |=> state_r == DWC_ST_IDLE && $stable(code_r))
    else $error("generator ran without run bit");

endmodule // dwc_waveform_config

/* File: verification/dwc_host_model.sv */
`timescale 1ns/1ps

module dwc_host_model
(
  input wire logic ref_clk,
  output logic reg_wr_en,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wr_data,
  input wire logic [15:0] reg_rd_data
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 16'h0000;
  end

  // ----------------------------------------
  // Register port cycles
  // ----------------------------------------
  // One-cycle strobe; released data is inverted so it never lingers
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_wr_data <= ~d;
  endtask

  // Readback is sampled two edges after the address is applied
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1 d = reg_rd_data;
  endtask

  // key release of lock
  // Run bit rides along to show the key write passes the lock
  task automatic unlock();
    wr_reg(8'hD3, 16'h5100);
  endtask
endmodule // dwc_host_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "dwc_cfg.svh"

module tb;
  import dwc_pkg::*;
  typedef struct packed {logic [15:0] data; logic [7:0] exp;} dwc_row_type;
  localparam logic [`DWC_TMR_W-1:0] SHORT_CYC [`DWC_NUM_SLEW] = '{default: `DWC_TMR_W'(4)};
  localparam dwc_row_type ROWS [6] = '{{16'h0000, 8'h04}, {16'h1008, 8'h81},
    {16'h0017, 8'h7A}, {16'h001A, 8'h21}, {16'h0005, 8'h5C}, {16'hDFE8, 8'h81}};
  localparam logic [5:0] STEPS [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10, 6'h20};
  // Shape, code to wait for, code that must follow it
  localparam logic [21:0] SHAPES [4] = '{{2'b00, 10'h050, 10'h030},
    {2'b01, 10'h050, 10'h010}, {2'b10, 10'h010, 10'h050}, {2'b11, 10'h050, 10'h010}};

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr_en;
  logic [7:0] reg_addr;
  logic [15:0] reg_wr_data;
  logic [15:0] reg_rd_data;
  logic [9:0] margin_high = 10'h050;
  logic [9:0] margin_low = 10'h010;
  logic [9:0] wave_code;
  logic wave_active;
  logic regs_locked;
  logic pmbus_enable;
  logic ref_enable;
  logic [1:0] output_gain_select;
  logic gain_active;
  logic powered_up;
  logic powerdown_hiz;
  logic powerdown_pulldown;
  logic [7:0] outs;
  logic [15:0] rd;
  logic [9:0] held;
  int fail_count = 0;
  int check_count = 0;

  assign outs = {pmbus_enable, ref_enable, output_gain_select, gain_active, powered_up,
    powerdown_hiz, powerdown_pulldown};

  always #2.5 ref_clk = ~ref_clk;

  dwc_waveform_config #(.CODE_W(10), .STEP_CYC(SHORT_CYC)) dwc_waveform_config_i (
    .ref_clk(ref_clk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .margin_high(margin_high),
    .margin_low(margin_low), .wave_code(wave_code), .wave_active(wave_active),
    .regs_locked(regs_locked), .pmbus_enable(pmbus_enable), .ref_enable(ref_enable),
    .output_gain_select(output_gain_select), .gain_active(gain_active),
    .powered_up(powered_up), .powerdown_hiz(powerdown_hiz),
    .powerdown_pulldown(powerdown_pulldown));

  dwc_host_model dwc_host_model_i (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait until the code equals (eq=1) or leaves (eq=0) a value
  task automatic wait_for(input logic eq, input logic [9:0] v);
    int n;
    n = 0;
    while (((wave_code === v) != eq) && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, n >= 200}, 16'h0000);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    fail_count++;
    conclude();
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    dwc_host_model_i.rd_reg(8'hD1, rd);
    check(rd, 16'h01F0);
    check({8'h00, outs}, 16'h0002);
    dwc_host_model_i.rd_reg(8'h25, rd);
    check(rd, 16'h0000);
    foreach (ROWS[i])
    begin
      dwc_host_model_i.wr_reg(8'hD1, ROWS[i].data);
      dwc_host_model_i.rd_reg(8'hD1, rd);
      check(rd, ROWS[i].data);
      check({8'h00, outs}, {8'h00, ROWS[i].exp});
    end
    dwc_host_model_i.wr_reg(8'hD3, 16'h0100);
    @(negedge ref_clk);
    check({15'h0000, wave_active}, 16'h0001);
    // Square with no slew toggles on every cycle once started
    repeat (4) @(negedge ref_clk);
    held = wave_code;
    @(negedge ref_clk);
    check({6'h00, wave_code ^ held}, 16'h0040);
    foreach (SHAPES[i])
    begin
      dwc_host_model_i.wr_reg(8'hD1, {SHAPES[i][21:20], 14'h0E00});
      repeat (3) @(posedge ref_clk);
      wait_for(1'b1, SHAPES[i][19:10]);
      wait_for(1'b0, SHAPES[i][19:10]);
      check({6'h00, wave_code}, {6'h00, SHAPES[i][9:0]});
    end
    margin_high <= 10'h200;
    for (int s = 0; s < 8; s++)
    begin
      dwc_host_model_i.wr_reg(8'hD1, {4'h4, s[2:0], 9'h000});
      repeat (3) @(posedge ref_clk);
      wait_for(1'b1, 10'h010);
      wait_for(1'b0, 10'h010);
      check({6'h00, wave_code}, {6'h00, 10'h010 + {4'h0, STEPS[s]}});
    end
    dwc_host_model_i.wr_reg(8'hD3, 16'h0000);
    @(negedge ref_clk);
    held = wave_code;
    repeat (20) @(posedge ref_clk);
    check({wave_active, 5'h00, wave_code}, {6'h00, held});
    dwc_host_model_i.wr_reg(8'hD1, 16'h2000);
    dwc_host_model_i.wr_reg(8'hD1, 16'h0000);
    dwc_host_model_i.wr_reg(8'hD3, 16'h6100);
    dwc_host_model_i.rd_reg(8'hD1, rd);
    check({rd[15:1], regs_locked}, 16'h2001);
    dwc_host_model_i.rd_reg(8'hD3, rd);
    check(rd, 16'h0000);
    dwc_host_model_i.unlock();
    dwc_host_model_i.rd_reg(8'hD3, rd);
    check(rd, 16'h0100);
    dwc_host_model_i.wr_reg(8'hD1, 16'h1000);
    dwc_host_model_i.rd_reg(8'hD1, rd);
    check({rd[15:1], regs_locked}, 16'h1000);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    dwc_host_model_i.rd_reg(8'hD1, rd);
    check(rd, 16'h01F0);
    check({7'h00, wave_active, outs}, 16'h0002);
    conclude();
  end
endmodule // tb
